// ---- dv/srv_peer_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module srv_peer_model
(
  input  wire srv_pkg::srv_local_req_t local_req,
  input  wire logic [2:0]              peer_req,
  output logic                         rx_wired_line_b,
  output logic                         tx_wired_line_b,
  output logic                         mdm_wired_line_b
);
  import srv_pkg::*;
  // ========
  // Pulled-up lines, low while any party requests
  assign rx_wired_line_b = !(peer_req[2] | local_req.rx_good
                           | local_req.rx_exc);
  assign tx_wired_line_b = !(peer_req[1] | local_req.tx);
  assign mdm_wired_line_b = !(peer_req[0] | local_req.modem);
endmodule
`default_nettype wire

// ---- dv/srv_request_vector_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module srv_request_vector_asserts
(
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire srv_pkg::srv_bus_req_t   bus,
  input wire logic [7:0]              rdata,
  input wire srv_pkg::srv_local_req_t local_req,
  input wire logic                    rx_wired_line_b,
  input wire logic                    ack_strobe,
  input wire srv_pkg::srv_ack_kind_t  ack_kind,
  input wire logic [2:0]              vector_type,
  input wire logic                    vector_valid
);
  import srv_pkg::*;
  logic       is_tx, is_mdm, has_req;
  logic [2:0] exp_type;
  logic [1:0] exp_ctx;
  assign is_tx = ack_kind == SRV_ACK_TX;
  assign is_mdm = ack_kind == SRV_ACK_MODEM;
  assign has_req = is_tx ? local_req.tx : is_mdm ? local_req.modem
                 : local_req.rx_good | local_req.rx_exc;
  assign exp_type = is_tx ? SRV_TYPE_TX : is_mdm ? SRV_TYPE_MODEM
                  : local_req.rx_exc ? SRV_TYPE_RX_EXC : SRV_TYPE_RX;
  assign exp_ctx = is_tx ? SRV_CTX_TX : is_mdm ? SRV_CTX_MODEM : SRV_CTX_RX;
  // ========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_taken; ack_strobe && has_req; endsequence
  sequence s_rd; bus.rd && bus.addr == SRV_STATUS_ADDR; endsequence
  AST_NO_RSVD: assert property (vector_valid |-> !vector_type[2]
    || vector_type == SRV_TYPE_RX_EXC) else $error("reserved type");
  AST_TYPE: assert property (s_taken |=> vector_valid
    && vector_type == $past(exp_type)) else $error("wrong type");
  AST_NONE: assert property (ack_strobe && !has_req |=> !vector_valid
    || vector_type == SRV_TYPE_NONE) else $error("no-request type");
  AST_CAUSE: assert property (vector_valid |-> $past(ack_strobe))
    else $error("vector without ack");
  AST_CTX: assert property (s_taken ##1 s_rd |=>
    rdata[7:6] == $past(exp_ctx, 2)) else $error("context");
  AST_EXT_ON: assert property ((!rx_wired_line_b) [*5] ##0 s_rd
    |=> rdata[5]) else $error("ext low");
  AST_EXT_OFF: assert property (rx_wired_line_b [*5] ##0 s_rd
    |=> !rdata[5]) else $error("ext high");
  AST_INT: assert property (s_rd |=> rdata[2] == $past(local_req.tx)
    && rdata[4] == $past(local_req.rx_good | local_req.rx_exc))
    else $error("local bits");
endmodule
bind srv_request_vector srv_request_vector_asserts u_chk (.clk(clk),
  .rst_b(rst_b), .bus(bus), .rdata(rdata), .local_req(local_req),
  .rx_wired_line_b(rx_wired_line_b), .ack_strobe(ack_strobe),
  .ack_kind(ack_kind), .vector_type(vector_type),
  .vector_valid(vector_valid));
`default_nettype wire

// ---- dv/test_service_request_vector.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_service_request_vector_status;
  import srv_pkg::*;
  logic           clk, rst_b, ack_strobe, ctx_pop, vector_valid, irq;
  logic           rx_wired_line_b, tx_wired_line_b, mdm_wired_line_b;
  srv_bus_req_t   bus;
  srv_local_req_t local_req;
  srv_ack_kind_t  ack_kind;
  logic [2:0]     peer_req, vector_type;
  logic [7:0]     rdata, rv;
  int             err_total = 0;
  int             comparisons = 0;
  always #10 clk = ~clk;
  srv_peer_model peer (.local_req(local_req), .peer_req(peer_req),
    .rx_wired_line_b(rx_wired_line_b), .tx_wired_line_b(tx_wired_line_b),
    .mdm_wired_line_b(mdm_wired_line_b));
  srv_request_vector uut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .local_req(local_req), .rx_wired_line_b(rx_wired_line_b),
    .tx_wired_line_b(tx_wired_line_b), .mdm_wired_line_b(mdm_wired_line_b),
    .ack_strobe(ack_strobe), .ack_kind(ack_kind), .ctx_pop(ctx_pop),
    .vector_type(vector_type), .vector_valid(vector_valid), .irq(irq));
  // ========
  // Bus and compare helpers
  task chk(input string n, input logic [7:0] e, g);
    comparisons++;
    err_total += int'(g !== e);
    if (g !== e) $display("mismatch %s exp %h got %h", n, e, g);
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task ack(input srv_ack_kind_t k, input logic [3:0] r,
           input logic [7:0] v, c);
    @(posedge clk);
    local_req <= r;
    ack_strobe <= 1'b1;
    ack_kind <= k;
    @(posedge clk);
    ack_strobe <= 1'b0;
    bus <= '{SRV_STATUS_ADDR, 8'h00, 1'b0, 1'b1};
    #1 chk("vector", v, {4'h0, vector_valid, vector_type});
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 if (c != 8'h00) chk("context", c, rdata & 8'hc0);
  endtask
  // ========
  // Scenarios
  task t_types;
    rd(SRV_STATUS_ADDR);
    chk("status reset", SRV_STATUS_RESET, rv);
    rd(8'h70);
    chk("unmapped", 8'h00, rv);
    wr(SRV_CONFIG_ADDR, 8'h01);
    ack(SRV_ACK_RX, 4'hc, 8'h0f, 8'h40);
    ack(SRV_ACK_RX, 4'h8, 8'h0b, 8'h40);
    ack(SRV_ACK_TX, 4'h2, 8'h0a, 8'hc0);
    ack(SRV_ACK_MODEM, 4'h1, 8'h09, 8'h80);
    @(posedge clk);
    ctx_pop <= 1'b1;
    @(posedge clk);
    ctx_pop <= 1'b0;
    rd(SRV_STATUS_ADDR);
    chk("popped", 8'hc0, rv & 8'hc0);
    ack(SRV_ACK_TX, 4'h8, 8'h08, 8'hc0);
    wr(SRV_CONFIG_ADDR, 8'h03);
    ack(SRV_ACK_MODEM, 4'h2, 8'h00, 8'hc0);
    $display("test types done");
  endtask
  task t_irq;
    @(posedge clk);
    local_req <= 4'h0;
    wr(SRV_IRQ_STAT_ADDR, 8'h07);
    @(posedge clk);
    local_req <= 4'h2;
    rd(SRV_IRQ_STAT_ADDR);
    chk("irq status", 8'h02, rv);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(SRV_IRQ_MASK_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk("irq on", 8'h01, {7'h0, irq});
    wr(SRV_IRQ_STAT_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk("irq off", 8'h00, {7'h0, irq});
    $display("test irq done");
  endtask
  task t_wired;
    @(posedge clk);
    local_req <= 4'h0;
    peer_req <= 3'h7;
    repeat (5) @(posedge clk);
    rd(SRV_STATUS_ADDR);
    chk("ext only", 8'h2a, rv & 8'h3f);
    @(posedge clk);
    local_req <= 4'h8;
    rd(SRV_STATUS_ADDR);
    chk("rx both", 8'h3a, rv & 8'h3f);
    $display("test wired done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    bus = '0;
    local_req = '0;
    ack_strobe = 1'b0;
    ack_kind = SRV_ACK_RX;
    ctx_pop = 1'b0;
    peer_req = 3'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_types;
    t_irq;
    t_wired;
    wrap_up;
  end
  initial
  begin
    #100000;
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- logic/srv_pkg.sv ----
`default_nettype none
package srv_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] SRV_STATUS_ADDR   = 8'h65;
  localparam logic [7:0] SRV_CONFIG_ADDR   = 8'h66;
  localparam logic [7:0] SRV_IRQ_STAT_ADDR = 8'h67;
  localparam logic [7:0] SRV_IRQ_MASK_ADDR = 8'h68;
  localparam logic [7:0] SRV_STATUS_RESET  = 8'h00;
  localparam logic [1:0] SRV_CONFIG_RESET  = 2'h0;
  localparam logic [2:0] SRV_IRQ_RESET     = 3'h0;

  // ==========================================================
  // Field positions
  localparam int SRV_CTX_LSB    = 6;
  localparam int SRV_RX_LSB     = 4;
  localparam int SRV_TX_LSB     = 2;
  localparam int SRV_MDM_LSB    = 0;
  localparam int SRV_CFG_REGACK = 0;
  localparam int SRV_CFG_CHAIN  = 1;

  // ==========================================================
  // Request type codes
  localparam logic [2:0] SRV_TYPE_NONE   = 3'h0;
  localparam logic [2:0] SRV_TYPE_MODEM  = 3'h1;
  localparam logic [2:0] SRV_TYPE_TX     = 3'h2;
  localparam logic [2:0] SRV_TYPE_RX     = 3'h3;
  localparam logic [2:0] SRV_TYPE_RX_EXC = 3'h7;

  // ==========================================================
  // Context codes
  localparam logic [1:0] SRV_CTX_NONE  = 2'h0;
  localparam logic [1:0] SRV_CTX_RX    = 2'h1;
  localparam logic [1:0] SRV_CTX_TX    = 2'h3;
  localparam logic [1:0] SRV_CTX_MODEM = 2'h2;
  localparam int         SRV_STACK_DEPTH = 4;

  // ==========================================================
  // Acknowledge kinds
  typedef enum logic [1:0]
  {
    SRV_ACK_RX    = 2'h0,
    SRV_ACK_TX    = 2'h1,
    SRV_ACK_MODEM = 2'h3
  } srv_ack_kind_t;

  typedef struct packed
  {
    logic rx_good;
    logic rx_exc;
    logic tx;
    logic modem;
  } srv_local_req_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } srv_bus_req_t;

endpackage
`default_nettype wire

// ---- logic/srv_request_vector.sv ----
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module srv_request_vector
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire srv_pkg::srv_bus_req_t   bus,
  output var  logic [7:0]              rdata,
  input  wire srv_pkg::srv_local_req_t local_req,
  input  wire logic                    rx_wired_line_b,
  input  wire logic                    tx_wired_line_b,
  input  wire logic                    mdm_wired_line_b,
  input  wire logic                    ack_strobe,
  input  wire srv_pkg::srv_ack_kind_t  ack_kind,
  input  wire logic                    ctx_pop,
  output var  logic [2:0]              vector_type,
  output var  logic                    vector_valid,
  output var  logic                    irq
);
  import srv_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic [2:0] wired_line;
  logic [2:0] next_wired_line;

  always_comb
  begin
    next_wired_line = wired_line;
    for (int i = 0; i < 3; i++)
    begin
      if (sync_b[i] == sync_c[i])
      begin
        next_wired_line[i] = ~sync_c[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Pins idle high: ones avoid a false request
      sync_a     <= 3'h7;
      sync_b     <= 3'h7;
      sync_c     <= 3'h7;
      wired_line <= 3'h0;
    end
    else
    begin
      sync_a     <= {rx_wired_line_b, tx_wired_line_b, mdm_wired_line_b};
      sync_b     <= sync_a;
      sync_c     <= sync_b;
      wired_line <= next_wired_line;
    end
  end

  // ==========================================================
  // Configuration and interrupt registers
  logic [1:0] config_reg;
  logic [1:0] next_config_reg;
  logic [2:0] irq_stat;
  logic [2:0] next_irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_mask;
  logic [2:0] events;
  logic [2:0] local_prev;
  logic [2:0] local_now;
  logic       register_ack_enable;
  logic       chain_cascade_enable;
  logic       next_irq;

  function automatic logic write_hit
  (
    input srv_bus_req_t req,
    input logic [7:0]   addr
  );
    return req.wr && (req.addr == addr);
  endfunction

  assign register_ack_enable  = config_reg[SRV_CFG_REGACK];
  assign chain_cascade_enable = config_reg[SRV_CFG_CHAIN];
  assign local_now = {local_req.rx_good | local_req.rx_exc,
                      local_req.tx, local_req.modem};
  assign events = local_now & ~local_prev;

  always_comb
  begin
    next_config_reg = config_reg;
    next_irq_mask   = irq_mask;
    next_irq_stat   = irq_stat;
    if (write_hit(bus, SRV_CONFIG_ADDR))
    begin
      next_config_reg = bus.wdata[1:0];
    end
    if (write_hit(bus, SRV_IRQ_MASK_ADDR))
    begin
      next_irq_mask = bus.wdata[2:0];
    end
    if (write_hit(bus, SRV_IRQ_STAT_ADDR))
    begin
      next_irq_stat = next_irq_stat & ~bus.wdata[2:0];
    end
    // Clear first, so an event in the same cycle wins
    next_irq_stat = next_irq_stat | events;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_reg <= SRV_CONFIG_RESET;
      irq_mask   <= SRV_IRQ_RESET;
      irq_stat   <= SRV_IRQ_RESET;
      local_prev <= 3'h0;
      irq        <= 1'b0;
    end
    else
    begin
      config_reg <= next_config_reg;
      irq_mask   <= next_irq_mask;
      irq_stat   <= next_irq_stat;
      local_prev <= local_now;
      irq        <= next_irq;
    end
  end

  // ==========================================================
  // Vector type selection
  function automatic logic [2:0] type_of
  (
    input srv_ack_kind_t  kind,
    input srv_local_req_t req
  );
    logic [2:0] code;
    code = SRV_TYPE_NONE;
    case (kind)
      SRV_ACK_RX:
      begin
        if (req.rx_exc)
        begin
          code = SRV_TYPE_RX_EXC;
        end
        else if (req.rx_good)
        begin
          code = SRV_TYPE_RX;
        end
      end
      SRV_ACK_TX:
      begin
        if (req.tx)
        begin
          code = SRV_TYPE_TX;
        end
      end
      SRV_ACK_MODEM:
      begin
        if (req.modem)
        begin
          code = SRV_TYPE_MODEM;
        end
      end
      default:
      begin
        code = SRV_TYPE_NONE;
      end
    endcase
    return code;
  endfunction

  function automatic logic [1:0] ctx_of(input srv_ack_kind_t kind);
    logic [1:0] c;
    c = SRV_CTX_NONE;
    case (kind)
      SRV_ACK_RX:    c = SRV_CTX_RX;
      SRV_ACK_TX:    c = SRV_CTX_TX;
      SRV_ACK_MODEM: c = SRV_CTX_MODEM;
      default:       c = SRV_CTX_NONE;
    endcase
    return c;
  endfunction

  // ==========================================================
  // Acknowledge and context stack
  logic [1:0] stack [SRV_STACK_DEPTH];
  logic [1:0] next_stack [SRV_STACK_DEPTH];
  logic [2:0] next_vector_type;
  logic       next_vector_valid;
  logic [2:0] ack_code;
  logic       ack_take;

  assign ack_code = type_of(ack_kind, local_req);
  // Without local request the acknowledge passes down the chain, unless register_ack_enable is set and chain_cascade_enable is clear
  assign ack_take = ack_strobe &&
                    ((ack_code != SRV_TYPE_NONE) ||
                     (register_ack_enable && !chain_cascade_enable));

  always_comb
  begin
    next_stack        = stack;
    next_vector_type  = vector_type;
    next_vector_valid = 1'b0;
    // Push wins over a pop; bottom entry lost on overflow
    if (ack_take)
    begin
      next_vector_type  = ack_code;
      next_vector_valid = 1'b1;
      for (int i = SRV_STACK_DEPTH - 1; i > 0; i--)
      begin
        next_stack[i] = stack[i-1];
      end
      next_stack[0] = ctx_of(ack_kind);
    end
    else if (ctx_pop)
    begin
      for (int i = 0; i < SRV_STACK_DEPTH - 1; i++)
      begin
        next_stack[i] = stack[i+1];
      end
      next_stack[SRV_STACK_DEPTH-1] = SRV_CTX_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < SRV_STACK_DEPTH; i++)
      begin
        stack[i] <= SRV_CTX_NONE;
      end
      vector_type  <= SRV_TYPE_NONE;
      vector_valid <= 1'b0;
    end
    else
    begin
      stack        <= next_stack;
      vector_type  <= next_vector_type;
      vector_valid <= next_vector_valid;
    end
  end

  // ==========================================================
  // Status register and read port
  logic [7:0] status_word;
  logic [7:0] next_rdata;

  always_comb
  begin
    status_word = SRV_STATUS_RESET;
    status_word[SRV_CTX_LSB +: 2] = stack[0];
    // External bit set alone means a chained peer is pending
    status_word[SRV_RX_LSB +: 2]  = {wired_line[2], local_now[2]};
    status_word[SRV_TX_LSB +: 2]  = {wired_line[1], local_now[1]};
    status_word[SRV_MDM_LSB +: 2] = {wired_line[0], local_now[0]};
  end

  always_comb
  begin
    // Zero except in the cycle after a read
    next_rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        SRV_STATUS_ADDR:   next_rdata = status_word;
        SRV_CONFIG_ADDR:   next_rdata = {6'h00, config_reg};
        SRV_IRQ_STAT_ADDR: next_rdata = {5'h00, irq_stat};
        SRV_IRQ_MASK_ADDR: next_rdata = {5'h00, irq_mask};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire
